/* src/qdac_pkg.sv */
// constants and types shared by both ends of the two-wire dac link
// Overview of operation
// - stop honoured anywhere except start's high pulse
// - master puts a clock between start and stop
// - back-to-back writes, with or without repeated start
// - master writes command, repeated start, then reads
// - slave pulls data low on ninth clock
// - slave releases ninth clock, samples master acknowledge
// - master abandons transfer on missing acknowledge
// - idle until start, address compared bit by bit
// - address lsb selects write (0) or read (1)
// - fixed upper address bits, lsb from select pin
// - write bytes are command nibble plus code
// - registers update on falling edge ending acknowledge
// - cut-short write changes nothing; master repeats it
// - command 1111 with zero code enters extended mode
// - extended byte sets chosen channels' power-down mode
// - read sends selected dac code in two bytes
// - no general call, no ten-bit addressing
// - clock gated from core after mismatch until start
// - mode bits: wake, float, 1k, 100k
// - 0000-0011 load and transfer; 0100-0111 input only
// - 10xx transfer then load; 1100-1111 group commands
// - power-on: codes zero, channels in 100k mode
package qdac_pkg;
  localparam logic [5:0]  ADDR_HI_VARIANT_L = 6'h1E;
  localparam logic [5:0]  ADDR_HI_VARIANT_M = 6'h2E;
  localparam int unsigned NUM_CH            = 4;
  localparam int unsigned CODE_W            = 12;
  localparam logic [3:0]  BIT_ACK           = 4'h8;
  localparam logic [3:0]  BIT_END           = 4'h9;
  // command nibbles and groups
  localparam logic [1:0]  GRP_LOAD_XFER     = 2'h0;
  localparam logic [1:0]  GRP_LOAD_INPUT    = 2'h1;
  localparam logic [1:0]  GRP_XFER_LOAD     = 2'h2;
  localparam logic [3:0]  CMD_LOAD_ALL      = 4'hC;
  localparam logic [3:0]  CMD_INPUT_ALL     = 4'hD;
  localparam logic [3:0]  CMD_UPDATE_ALL    = 4'hE;
  localparam logic [3:0]  CMD_EXTENDED      = 4'hF;
  // extended byte: mode in [1:0], channel selects a..d in [5:2]
  localparam int unsigned PD_MODE_LSB       = 0;
  localparam int unsigned PD_SEL_LSB        = 2;
  localparam logic [1:0]  PD_WAKE           = 2'h0;
  localparam logic [1:0]  PD_FLOAT          = 2'h1;
  localparam logic [1:0]  PD_1K             = 2'h2;
  localparam logic [1:0]  PD_100K           = 2'h3;
  localparam logic [11:0] CODE_RESET        = 12'h000;
  // controller register indices (avalon word addresses)
  localparam logic [1:0]  REG_CTRL          = 2'h0;
  localparam logic [1:0]  REG_TX            = 2'h1;
  localparam logic [1:0]  REG_RX            = 2'h2;
  localparam int unsigned CTRL_NWR_LSB      = 0;
  localparam int unsigned CTRL_RD_BIT       = 2;
  localparam int unsigned STAT_BUSY_BIT     = 0;
  localparam int unsigned STAT_NACK_BIT     = 1;
  // link timing
  localparam int unsigned CLK_PERIOD_NS     = 40;
  localparam int unsigned LINK_QUARTER_NS   = 800;
  localparam int unsigned LINK_QUARTER_CYC  =
    LINK_QUARTER_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    SL_IDLE  = 4'h1,
    SL_ADDR  = 4'h2,
    SL_WRITE = 4'h4,
    SL_READ  = 4'h8
  } qdac_sl_state_type;

  typedef enum logic [3:0] {
    MS_IDLE  = 4'h1,
    MS_START = 4'h2,
    MS_BITS  = 4'h4,
    MS_STOP  = 4'h8
  } qdac_ms_state_type;
endpackage

/* src/qdac_if.sv */
// open-drain two-wire link joining controller and dac port
`timescale 1ns/100ps
interface qdac_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // wired-and with pull-ups
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe,
                  input scl, sda);
  modport slave (output s_sda_o, s_sda_oe, input scl, sda);
endinterface

/* src/qdac_slave.sv */
// two-wire slave port and command decoder of the quad dac
`timescale 1ns/100ps
module qdac_slave #(
  parameter logic [5:0] ADDR_HIGH = qdac_pkg::ADDR_HI_VARIANT_L
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // two-wire link
  qdac_if.slave            bus,
  // address select pin
  input  wire logic        i_addr_sel,
  // per-channel state towards the analog side
  output logic [3:0][11:0] o_input_code,
  output logic [3:0][11:0] o_dac_code,
  output logic [3:0][1:0]  o_pd_mode
);
  qdac_pkg::qdac_sl_state_type state_q;

  logic [2:0]  scl_sh_q;
  logic [2:0]  sda_sh_q;
  logic [1:0]  sel_sh_q;
  logic        start_hi_q;
  logic [3:0]  cnt_q;
  logic [7:0]  sh_q;
  logic        mack_q;
  logic        rbyte_q;
  logic        wbyte_q;
  logic        ext_q;
  logic [3:0]  cmd_q;
  logic [3:0]  hi_q;
  logic [1:0]  rd_ch_q;
  logic [7:0]  tx_q;
  logic [7:0]  tx_d;
  logic        sda_oe_q;
  logic [11:0] in_q  [4];
  logic [11:0] dac_q [4];
  logic [1:0]  pd_q  [4];

  logic        rise;
  logic        fall;
  logic        start_ev;
  logic        stop_ok;
  logic        active;
  logic        ack_end;
  logic        wr_done;
  logic        rd_go;
  logic        rd_more;
  logic [6:0]  exp_addr;
  logic [11:0] word;
  logic [11:0] rd_code;

  // link pins pass two flops before any logic sees them
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      scl_sh_q <= 3'h7;
      sda_sh_q <= 3'h7;
      sel_sh_q <= 2'h0;
    end else begin
      scl_sh_q <= {scl_sh_q[1:0], bus.scl};
      sda_sh_q <= {sda_sh_q[1:0], bus.sda};
      sel_sh_q <= {sel_sh_q[0], i_addr_sel};
    end
  end

  assign active   = (state_q != qdac_pkg::SL_IDLE);
  assign rise     = active & scl_sh_q[1] & ~scl_sh_q[2];
  assign fall     = active & ~scl_sh_q[1] & scl_sh_q[2];
  assign start_ev = scl_sh_q[1] & scl_sh_q[2] & sda_sh_q[2] & ~sda_sh_q[1];
  assign stop_ok  = scl_sh_q[1] & scl_sh_q[2] & ~sda_sh_q[2] & sda_sh_q[1]
                    & ~start_hi_q;
  assign ack_end  = fall & (cnt_q == qdac_pkg::BIT_END);
  assign wr_done  = ack_end & (state_q == qdac_pkg::SL_WRITE);
  assign rd_go    = ack_end & (state_q == qdac_pkg::SL_ADDR) & sh_q[0];
  assign rd_more  = ack_end & (state_q == qdac_pkg::SL_READ) & ~mack_q
                    & ~rbyte_q;
  assign exp_addr = {ADDR_HIGH, sel_sh_q[1]};
  assign word     = {hi_q, sh_q};
  assign rd_code  = dac_q[rd_ch_q];

  // start and stop sharing one high pulse is illegal on the master side
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      start_hi_q <= 1'b0;
    end else if (start_ev) begin
      start_hi_q <= 1'b1;
    end else if (~scl_sh_q[1]) begin
      start_hi_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= qdac_pkg::SL_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      mack_q  <= 1'b1;
      rbyte_q <= 1'b0;
    end else if (start_ev) begin
      state_q <= qdac_pkg::SL_ADDR;
      cnt_q   <= 4'h0;
    end else if (stop_ok) begin
      state_q <= qdac_pkg::SL_IDLE;
    end else if (rise) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q < qdac_pkg::BIT_ACK) begin
        sh_q <= {sh_q[6:0], sda_sh_q[1]};
      end
      if (cnt_q == qdac_pkg::BIT_ACK) begin
        mack_q <= sda_sh_q[1];
      end
      if (state_q == qdac_pkg::SL_ADDR && cnt_q < 4'h7 &&
          sda_sh_q[1] != exp_addr[3'(3'h6 - cnt_q[2:0])]) begin
        state_q <= qdac_pkg::SL_IDLE;
      end
    end else if (ack_end) begin
      cnt_q <= 4'h0;
      unique case (state_q)
        qdac_pkg::SL_ADDR: begin
          state_q <= sh_q[0] ? qdac_pkg::SL_READ : qdac_pkg::SL_WRITE;
          rbyte_q <= 1'b0;
        end
        qdac_pkg::SL_READ: begin
          // second byte only after master acknowledge
          if (rd_more) begin
            rbyte_q <= 1'b1;
          end else begin
            state_q <= qdac_pkg::SL_IDLE;
          end
        end
        // writes continue in the same transfer
        qdac_pkg::SL_WRITE: state_q <= qdac_pkg::SL_WRITE;
        qdac_pkg::SL_IDLE:  state_q <= qdac_pkg::SL_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wbyte_q <= 1'b0;
      ext_q   <= 1'b0;
      cmd_q   <= 4'h0;
      hi_q    <= 4'h0;
      rd_ch_q <= 2'h0;
    end else if (start_ev) begin
      wbyte_q <= 1'b0;
      ext_q   <= 1'b0;
    end else if (wr_done) begin
      if (~wbyte_q) begin
        cmd_q <= sh_q[7:4];
        hi_q  <= sh_q[3:0];
        if (sh_q[7:4] == qdac_pkg::CMD_EXTENDED) begin
          unique case (sh_q[3:0])
            4'h0:    {wbyte_q, ext_q} <= 2'h3;
            4'h1:    rd_ch_q <= 2'h0;
            4'h2:    rd_ch_q <= 2'h1;
            4'h4:    rd_ch_q <= 2'h2;
            4'h8:    rd_ch_q <= 2'h3;
            default: rd_ch_q <= rd_ch_q;
          endcase
        end else if (sh_q[7:4] != qdac_pkg::CMD_UPDATE_ALL) begin
          wbyte_q <= 1'b1;
        end
      end else begin
        wbyte_q <= 1'b0;
        ext_q   <= 1'b0;
      end
    end
  end

  always_comb begin
    tx_d = tx_q;
    if (rd_go) begin
      tx_d = {qdac_pkg::CMD_EXTENDED, rd_code[11:8]};
    end else if (rd_more) begin
      tx_d = rd_code[7:0];
    end else if (fall && state_q == qdac_pkg::SL_READ &&
                 cnt_q != 4'h0 && cnt_q < qdac_pkg::BIT_ACK) begin
      tx_d = {tx_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_q <= 8'h00;
    end else begin
      tx_q <= tx_d;
    end
  end

  // open drain: enable only to pull low
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sda_oe_q <= 1'b0;
    end else if (start_ev || stop_ok) begin
      sda_oe_q <= 1'b0;
    end else if (fall) begin
      if (cnt_q == qdac_pkg::BIT_ACK) begin
        sda_oe_q <= (state_q != qdac_pkg::SL_READ);
      end else if (ack_end) begin
        sda_oe_q <= (rd_go | rd_more) & ~tx_d[7];
      end else begin
        sda_oe_q <= (state_q == qdac_pkg::SL_READ) & ~tx_d[7];
      end
    end else if (~active) begin
      sda_oe_q <= 1'b0;
    end
  end

  assign bus.s_sda_o  = 1'b0;
  assign bus.s_sda_oe = sda_oe_q;

  for (genvar ch = 0; ch < qdac_pkg::NUM_CH; ch++) begin : g_ch
    logic sel;
    logic upd;
    assign sel = (cmd_q[1:0] == 2'(ch));
    // commits only at end of completed byte
    assign upd = wr_done & wbyte_q & ~ext_q;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        in_q[ch] <= qdac_pkg::CODE_RESET;
      end else if (upd) begin
        if (cmd_q[3:2] != 2'h3) begin
          if (sel) begin
            in_q[ch] <= word;
          end
        end else if (cmd_q == qdac_pkg::CMD_LOAD_ALL ||
                     cmd_q == qdac_pkg::CMD_INPUT_ALL) begin
          in_q[ch] <= word;
        end
      end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        dac_q[ch] <= qdac_pkg::CODE_RESET;
      end else if (wr_done && ~wbyte_q &&
                   sh_q[7:4] == qdac_pkg::CMD_UPDATE_ALL) begin
        dac_q[ch] <= in_q[ch];
      end else if (upd) begin
        if (cmd_q[3:2] == qdac_pkg::GRP_LOAD_XFER) begin
          dac_q[ch] <= sel ? word : in_q[ch];
        end else if (cmd_q[3:2] == qdac_pkg::GRP_XFER_LOAD) begin
          dac_q[ch] <= in_q[ch];
        end else if (cmd_q == qdac_pkg::CMD_LOAD_ALL) begin
          dac_q[ch] <= word;
        end
      end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        pd_q[ch] <= qdac_pkg::PD_100K;
      end else if (wr_done && wbyte_q && ext_q &&
                   sh_q[qdac_pkg::PD_SEL_LSB + ch]) begin
        pd_q[ch] <= sh_q[qdac_pkg::PD_MODE_LSB +: 2];
      end
    end

    assign o_input_code[ch] = in_q[ch];
    assign o_dac_code[ch]   = dac_q[ch];
    assign o_pd_mode[ch]    = pd_q[ch];
  end
endmodule

/* src/qdac_master.sv */
// two-wire bus controller driven from avalon-mm registers
`timescale 1ns/100ps
module qdac_master #(
  parameter int unsigned QUARTER_CYC = qdac_pkg::LINK_QUARTER_CYC
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // avalon-mm slave
  input  wire logic [1:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // two-wire link
  qdac_if.master           bus
);
  qdac_pkg::qdac_ms_state_type state_q;

  logic [15:0] div_q;
  logic [1:0]  sda_sh_q;
  logic [1:0]  q_q;
  logic [3:0]  bc_q;
  logic [1:0]  bi_q;
  logic        raddr_q;
  logic        rdata_q;
  logic [1:0]  nwr_q;
  logic        rd_q;
  logic [23:0] tx_q;
  logic [15:0] rx_q;
  logic        ackbit_q;
  logic        nack_q;
  logic        scl_oe_q;
  logic        sda_oe_q;
  logic        wait_q;
  logic [31:0] rdata_q32;

  logic        tick;
  logic        idle;
  logic        go;
  logic [7:0]  cur_tx;
  logic        cur_bit;

  assign idle    = (state_q == qdac_pkg::MS_IDLE);
  assign tick    = (div_q == 16'(QUARTER_CYC - 1));
  assign go      = ~wait_q & i_avs_write & idle &
                   (i_avs_address == qdac_pkg::REG_CTRL);
  assign cur_tx  = raddr_q ? {tx_q[7:1], 1'b1} : 8'(tx_q >> {bi_q, 3'h0});
  assign cur_bit = cur_tx[3'(3'h7 - bc_q[2:0])];

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sda_sh_q <= 2'h3;
    end else begin
      sda_sh_q <= {sda_sh_q[0], bus.sda};
    end
  end

  // quarter-bit divider, still while idle
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_q <= 16'h0000;
    end else if (idle || tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q  <= qdac_pkg::MS_IDLE;
      q_q      <= 2'h0;
      bc_q     <= 4'h0;
      bi_q     <= 2'h0;
      raddr_q  <= 1'b0;
      rdata_q  <= 1'b0;
      rx_q     <= 16'h0000;
      ackbit_q <= 1'b1;
      nack_q   <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (idle) begin
      if (go) begin
        state_q <= qdac_pkg::MS_START;
        q_q     <= 2'h0;
        bi_q    <= 2'h0;
        raddr_q <= 1'b0;
        rdata_q <= 1'b0;
        nack_q  <= 1'b0;
      end
    end else if (tick) begin
      q_q <= q_q + 2'h1;
      unique case (state_q)
        qdac_pkg::MS_START: begin
          // also serves as repeated start from a low clock
          unique case (q_q)
            2'h0: sda_oe_q <= 1'b0;
            2'h1: scl_oe_q <= 1'b0;
            2'h2: sda_oe_q <= 1'b1;
            2'h3: begin
              scl_oe_q <= 1'b1;
              bc_q     <= 4'h0;
              state_q  <= qdac_pkg::MS_BITS;
            end
          endcase
        end
        qdac_pkg::MS_BITS: begin
          unique case (q_q)
            2'h0: begin
              if (rdata_q) begin
                // acknowledge first read byte, not the second
                sda_oe_q <= (bc_q == qdac_pkg::BIT_ACK) && (bi_q == 2'h0);
              end else begin
                sda_oe_q <= (bc_q < qdac_pkg::BIT_ACK) && ~cur_bit;
              end
            end
            2'h1: scl_oe_q <= 1'b0;
            2'h2: begin
              if (rdata_q && bc_q < qdac_pkg::BIT_ACK) begin
                rx_q <= {rx_q[14:0], sda_sh_q[1]};
              end
              ackbit_q <= sda_sh_q[1];
            end
            2'h3: begin
              scl_oe_q <= 1'b1;
              bc_q     <= bc_q + 4'h1;
              if (bc_q == qdac_pkg::BIT_ACK) begin
                bc_q <= 4'h0;
                if (~rdata_q && ackbit_q) begin
                  nack_q  <= 1'b1;
                  state_q <= qdac_pkg::MS_STOP;
                end else if (rdata_q) begin
                  bi_q <= 2'h1;
                  if (bi_q != 2'h0) begin
                    state_q <= qdac_pkg::MS_STOP;
                  end
                end else if (raddr_q) begin
                  raddr_q <= 1'b0;
                  rdata_q <= 1'b1;
                  bi_q    <= 2'h0;
                end else if (bi_q + 2'h1 < nwr_q) begin
                  bi_q <= bi_q + 2'h1;
                end else if (rd_q) begin
                  raddr_q <= 1'b1;
                  state_q <= qdac_pkg::MS_START;
                end else begin
                  state_q <= qdac_pkg::MS_STOP;
                end
              end
            end
          endcase
        end
        qdac_pkg::MS_STOP: begin
          // stop always a full clock after start
          unique case (q_q)
            2'h0: sda_oe_q <= 1'b1;
            2'h1: scl_oe_q <= 1'b0;
            2'h2: sda_oe_q <= 1'b0;
            2'h3: state_q  <= qdac_pkg::MS_IDLE;
          endcase
        end
        qdac_pkg::MS_IDLE: state_q <= qdac_pkg::MS_IDLE;
      endcase
    end
  end

  // answer one cycle after the request is seen
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~((i_avs_read | i_avs_write) & wait_q);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_q32 <= 32'h00000000;
    end else if (wait_q && i_avs_read) begin
      unique case (i_avs_address)
        qdac_pkg::REG_CTRL: rdata_q32 <= {30'h0, nack_q, ~idle};
        qdac_pkg::REG_TX:   rdata_q32 <= {8'h00, tx_q};
        qdac_pkg::REG_RX:   rdata_q32 <= {16'h0000, rx_q};
        default:            rdata_q32 <= 32'h00000000;
      endcase
    end
  end

  // settings frozen while a transfer runs
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_q  <= 24'h000000;
      nwr_q <= 2'h0;
      rd_q  <= 1'b0;
    end else if (~wait_q && i_avs_write && idle) begin
      if (i_avs_address == qdac_pkg::REG_TX) begin
        tx_q <= i_avs_writedata[23:0];
      end else if (i_avs_address == qdac_pkg::REG_CTRL) begin
        nwr_q <= i_avs_writedata[qdac_pkg::CTRL_NWR_LSB +: 2];
        rd_q  <= i_avs_writedata[qdac_pkg::CTRL_RD_BIT];
      end
    end
  end

  assign o_avs_readdata    = rdata_q32;
  assign o_avs_waitrequest = wait_q;
  assign bus.m_scl_o       = 1'b0;
  assign bus.m_scl_oe      = scl_oe_q;
  assign bus.m_sda_o       = 1'b0;
  assign bus.m_sda_oe      = sda_oe_q;
endmodule

/* testbench/qdac_link_assertions.sv */
// protocol assertions watching the two-wire link between both ends
`timescale 1ns/100ps
module qdac_link_assertions (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // link signals
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic [4:0] rise_cnt_q;
  logic       start_now;
  logic       stop_now;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  assign start_now = scl && scl_q && sda_q && !sda;
  assign stop_now  = scl && scl_q && !sda_q && sda;

  // scl rises since the last start, saturating
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      rise_cnt_q <= 5'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_now) begin
        rise_cnt_q <= 5'h00;
      end else if (scl && !scl_q && rise_cnt_q != 5'h1F) begin
        rise_cnt_q <= rise_cnt_q + 5'h01;
      end
    end
  end

  sequence scl_low_soon;
    ##[1:400] !scl;
  endsequence

  AST_OPEN_DRAIN: assert property (
    (m_scl_oe || m_sda_oe || s_sda_oe) |-> !(m_scl_o || m_sda_o || s_sda_o))
    else $error("a link driver pushes a high level");
  AST_RESET_RELEASED: assert property (
    $past(i_sys_rst) |-> !m_scl_oe && !m_sda_oe && !s_sda_oe)
    else $error("link not released after reset");
  AST_SLAVE_EDGE_LOW: assert property (
    $changed(s_sda_oe) |-> !scl && !$past(scl))
    else $error("slave moved data while clock high");
  AST_ACK_HOLD: assert property (
    (scl && scl_q && rise_cnt_q == 5'h09 && s_sda_oe) |=> s_sda_oe || !scl)
    else $error("acknowledge dropped in ninth high");
  AST_ADDR_QUIET: assert property (
    (scl && scl_q && rise_cnt_q >= 5'h01 && rise_cnt_q <= 5'h08)
      |-> !s_sda_oe)
    else $error("slave drove data during address bits");
  AST_STOP_QUIET: assert property (
    stop_now |=> !s_sda_oe [*8])
    else $error("slave drove data after stop");
  AST_START_CLOCKS: assert property (
    start_now |-> scl_low_soon)
    else $error("no clock pulse after start");
  AST_START_NO_STOP: assert property (
    start_now |=> !stop_now until !scl)
    else $error("stop in the high pulse of a start");
endmodule

/* testbench/test_quad_dac_i2c_slave_command_port.sv */
// self-checking bench: avalon controller driving the dac port
`timescale 1ns/100ps
module test_quad_dac_i2c_slave_command_port;
  logic             i_clk;
  logic             i_sys_rst;
  logic             addr_sel;
  logic             av_rd;
  logic             av_wr;
  logic             av_wait;
  logic [1:0]       av_addr;
  logic [31:0]      av_wdata;
  logic [31:0]      av_rdata;
  logic [31:0]      q;
  logic [7:0]       abyte;
  logic [3:0][11:0] in_code;
  logic [3:0][11:0] dac_code;
  logic [3:0][11:0] in_m;
  logic [3:0][11:0] dac_m;
  logic [3:0][1:0]  pd_mode;
  logic [3:0][1:0]  pd_m;
  int               num_errors;
  int               samples_checked;
  int               cycles;
  // rows: byte count incl. address, command byte, data byte
  logic [17:0] rows [20] = '{18'h3C123, 18'h34ABC, 18'h35501, 18'h36FFF,
    18'h37777, 18'h30800, 18'h3D333, 18'h31AAA, 18'h32BBB, 18'h33CCC,
    18'h38444, 18'h39555, 18'h3A666, 18'h3B777, 18'h2E000, 18'h20500,
    18'h3F03C, 18'h3F005, 18'h3F01A, 18'h3F023};
  logic [7:0]  bad [4] = '{8'h7A, 8'hB8, 8'h00, 8'hF0};

  assign abyte = {qdac_pkg::ADDR_HI_VARIANT_L, addr_sel, 1'b0};

  qdac_if lnk();
  qdac_master #(.QUARTER_CYC(4)) qdac_master_inst (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_avs_address(av_addr), .i_avs_read(av_rd),
    .i_avs_write(av_wr), .i_avs_writedata(av_wdata),
    .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait), .bus(lnk));
  qdac_slave qdac_slave_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .bus(lnk), .i_addr_sel(addr_sel), .o_input_code(in_code),
    .o_dac_code(dac_code), .o_pd_mode(pd_mode));
  qdac_link_assertions qdac_link_assertions_inst (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .m_scl_o(lnk.m_scl_o), .m_scl_oe(lnk.m_scl_oe),
    .m_sda_o(lnk.m_sda_o), .m_sda_oe(lnk.m_sda_oe), .s_sda_o(lnk.s_sda_o),
    .s_sda_oe(lnk.s_sda_oe), .scl(lnk.scl), .sda(lnk.sda));

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [47:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // request held until waitrequest is sampled low
  task automatic av(input logic w, input logic [1:0] a, input logic [31:0] d);
    @(posedge i_clk);
    av_addr  <= a;
    av_wr    <= w;
    av_rd    <= !w;
    av_wdata <= d;
    do @(posedge i_clk); while (av_wait !== 1'b0);
    q = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask

  task automatic xfer(input logic [2:0] ctl, input logic [23:0] tx);
    av(1'b1, qdac_pkg::REG_TX, {8'h00, tx});
    av(1'b1, qdac_pkg::REG_CTRL, {29'h0, ctl});
    do av(1'b0, qdac_pkg::REG_CTRL, 32'h0); while (q[0] !== 1'b0);
  endtask

  task automatic do_reset();
    i_sys_rst <= 1'b1;
    repeat (20) @(posedge i_clk);
    in_m  = '0;
    dac_m = '0;
    pd_m  = '1;
    chk("input", in_code, in_m);
    chk("dac", dac_code, dac_m);
    chk("pd", 48'(pd_mode), 48'(pd_m));
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask

  // reference behaviour of one write transfer
  task automatic model(input logic [17:0] r);
    logic [3:0]  c;
    logic [11:0] v;
    c = r[15:12];
    v = r[11:0];
    if (r[17:16] == 2'h2 && c == 4'hE) begin
      dac_m = in_m;
    end else if (r[17:16] == 2'h3 && c == 4'hF) begin
      for (int i = 0; i < 4; i++) if (r[2+i]) pd_m[i] = r[1:0];
    end else if (r[17:16] == 2'h3) begin
      // input-only groups (01xx, 1101) leave the dac registers alone
      if (c[3:2] == 2'h0 || c[3:2] == 2'h2) dac_m = in_m;
      if (c[3:2] == 2'h3) in_m = {4{v}};
      else in_m[c[1:0]] = v;
      if (c[3:2] == 2'h0 || c == 4'hC) dac_m[c[1:0]] = v;
      if (c == 4'hC) dac_m = {4{v}};
    end
  endtask

  task automatic run_row(input logic [17:0] r);
    xfer({1'b0, r[17:16]}, {r[7:0], r[15:8], abyte});
    model(r);
    chk("input", in_code, in_m);
    chk("dac", dac_code, dac_m);
    chk("pd", 48'(pd_mode), 48'(pd_m));
  endtask

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // hang guard, well above the expected run length
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    i_sys_rst = 1'b1;
    addr_sel  = 1'b0;
    av_rd     = 1'b0;
    av_wr     = 1'b0;
    av_addr   = 2'h0;
    av_wdata  = 32'h0;
    do_reset();
    $display("test reset done");
    foreach (rows[k]) run_row(rows[k]);
    $display("test commands done");
    for (int ch = 0; ch < 4; ch++) begin
      xfer(3'h6, {8'h00, 8'hF0 | (8'h01 << ch), abyte});
      av(1'b0, qdac_pkg::REG_RX, 32'h0);
      chk("readback", 48'(q[15:0]), 48'({4'hF, dac_m[ch]}));
    end
    $display("test readback done");
    foreach (bad[k]) begin
      xfer(3'h3, {8'h7B, 8'hC7, bad[k]});
      chk("nack", 48'(q[1]), 48'h1);
      chk("dac", dac_code, dac_m);
    end
    addr_sel <= 1'b1;
    repeat (4) @(posedge i_clk);
    run_row(18'h3C421);
    chk("nack", 48'(q[1]), 48'h0);
    $display("test address done");
    av(1'b1, qdac_pkg::REG_TX, {8'h00, 8'h55, 8'hC8, abyte});
    av(1'b1, qdac_pkg::REG_CTRL, 32'h3);
    repeat (200) @(posedge i_clk);
    do_reset();
    run_row(18'h30987);
    $display("test midreset done");
    summarize();
  end
endmodule
